// ==== logic/display_audio_link_codec_port.sv ====
// codec end of the serial audio link: framing, tags, outbound and inbound data
module display_audio_link_codec_port
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        link_bit_clock_in,
    input  wire logic        link_reset_n_in,
    input  wire logic        link_frame_sync_in,
    input  wire logic        link_outbound_serial_in,
    input  wire logic        link_inbound_serial_in,
    output logic             link_inbound_serial_out,
    output logic             link_inbound_serial_oe_out,
    input  wire logic [15:0] inbound_word_in,
    output logic             inbound_taken_out,
    output logic             locked_out,
    output logic             frame_start_out,
    output logic [3:0]       stream_tag_out,
    output logic             stream_tag_valid_out,
    output logic [15:0]      outbound_word_out,
    output logic             outbound_word_valid_out
);

    // ****************************************
    // pin sampling
    // ****************************************
    audio_link_pkg::link_pins_t  pins;
    audio_link_pkg::port_state_t st_r;
    audio_link_pkg::port_state_t st_nxt;
    logic                        link_rst;
    logic [7:0]                  hist_next;
    logic                        sync_done;

    link_sampler u_sampler
    (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .bit_clock_in (link_bit_clock_in),
        .reset_n_in   (link_reset_n_in),
        .sync_in      (link_frame_sync_in),
        .sdo_in       (link_outbound_serial_in),
        .pins_out     (pins)
    );

    // link reset pin and local reset both clear the link logic [RULE2]
    assign link_rst  = rst_in | ~pins.reset_n;
    assign hist_next = {st_r.sync_hist[6:0], pins.sync};
    assign sync_done = pins.fall
                     && st_r.sync_cnt == audio_link_pkg::SYNC_LAST - 4'h1;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt             = st_r;
        st_nxt.frame_start = 1'h0;
        st_nxt.tag_valid   = 1'h0;
        st_nxt.out_valid   = 1'h0;
        st_nxt.in_taken    = 1'h0;

        // outbound bits taken on both edges of the bit clock [RULE5]
        if (st_r.state == audio_link_pkg::LOCKED && (pins.rise || pins.fall))
        begin
            st_nxt.out_sh  = {st_r.out_sh[14:0], pins.sdo};
            st_nxt.out_cnt = st_r.out_cnt + 5'h1;
            if (st_r.out_cnt == audio_link_pkg::WORD_LAST - 5'h1)
            begin
                st_nxt.out_word  = {st_r.out_sh[14:0], pins.sdo};
                st_nxt.out_valid = 1'h1;
                st_nxt.out_cnt   = 5'h0;
            end
        end

        // inbound bit changes after a rise, held for one period [RULE4]
        if (st_r.state == audio_link_pkg::LOCKED && pins.rise)
        begin
            if (st_r.in_left != 5'h0)
            begin
                st_nxt.sdi     = st_r.in_sh[15];
                st_nxt.in_sh   = {st_r.in_sh[14:0], 1'h0};
                st_nxt.in_left = st_r.in_left - 5'h1;
            end
            else
            begin
                st_nxt.sdi = 1'h0;
            end
        end

        // sync is collected on falling edges, away from its own change;
        // a sync rise inside a pattern is a pattern bit, not a new start
        if (pins.fall)
        begin
            st_nxt.sync_prev = pins.sync;
            if (st_r.sync_cnt != 4'h0)
            begin
                st_nxt.sync_hist = hist_next;
                st_nxt.sync_cnt  = st_r.sync_cnt + 4'h1;
            end
            else if (!st_r.sync_prev && pins.sync)
            begin
                st_nxt.sync_cnt  = 4'h1;
                st_nxt.sync_hist = 8'h01;
            end
        end

        // whole sync pattern seen: frame boundary or stream tag [RULE3]
        if (sync_done)
        begin
            st_nxt.sync_cnt = 4'h0;
            case (st_r.state)
                audio_link_pkg::WAIT_SYNC:
                begin
                    // parsing starts only at a valid frame mark [RULE6]
                    if (hist_next == audio_link_pkg::FRAME_MARK)
                    begin
                        st_nxt.state = audio_link_pkg::LOCKED;
                    end
                end
                audio_link_pkg::LOCKED:
                begin
                    if (hist_next[7:4] == audio_link_pkg::TAG_LEAD
                        && hist_next != audio_link_pkg::FRAME_MARK)
                    begin
                        st_nxt.tag       = hist_next[3:0];
                        st_nxt.tag_valid = 1'h1;
                    end
                end
                default:
                begin
                    st_nxt.state = audio_link_pkg::WAIT_SYNC;
                end
            endcase
            if (hist_next == audio_link_pkg::FRAME_MARK)
            begin
                st_nxt.frame_start = 1'h1;
                st_nxt.out_cnt     = 5'h0;
                st_nxt.in_sh       = inbound_word_in;
                st_nxt.in_left     = audio_link_pkg::WORD_LAST;
                st_nxt.in_taken    = 1'h1;
            end
        end

        st_nxt.sdi_oe = (st_nxt.state == audio_link_pkg::LOCKED);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (link_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign link_inbound_serial_out    = st_r.sdi;
    assign link_inbound_serial_oe_out = st_r.sdi_oe;
    assign inbound_taken_out          = st_r.in_taken;
    assign locked_out                 = st_r.state == audio_link_pkg::LOCKED;
    assign frame_start_out            = st_r.frame_start;
    assign stream_tag_out             = st_r.tag;
    assign stream_tag_valid_out       = st_r.tag_valid;
    assign outbound_word_out          = st_r.out_word;
    assign outbound_word_valid_out    = st_r.out_valid;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_frame_mark;
        sync_done && hist_next == audio_link_pkg::FRAME_MARK && !link_rst;
    endsequence

    sequence s_frame_flags;
        frame_start_out && inbound_taken_out && locked_out;
    endsequence

    property p_link_reset;
        @(posedge ref_clk_in) disable iff (rst_in)
        !pins.reset_n |=> !locked_out && !link_inbound_serial_oe_out
                          && !link_inbound_serial_out;
    endproperty
    a_link_reset: assert property (p_link_reset) // [RULE2]
        else $error("link logic not cleared under link reset");

    property p_frame_mark;
        @(posedge ref_clk_in) disable iff (link_rst)
        s_frame_mark |=> s_frame_flags;
    endproperty
    a_frame_mark: assert property (p_frame_mark) // [RULE3]
        else $error("frame mark did not start a frame");

    property p_lock_on_sync;
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(locked_out) |-> frame_start_out;
    endproperty
    a_lock_on_sync: assert property (p_lock_on_sync) // [RULE6]
        else $error("port locked without a frame mark");

    property p_sdi_after_rise;
        @(posedge ref_clk_in) disable iff (link_rst)
        $changed(link_inbound_serial_out) |-> $past(pins.rise)
                                              || $past(link_rst);
    endproperty
    a_sdi_after_rise: assert property (p_sdi_after_rise) // [RULE4]
        else $error("inbound bit changed away from a rising edge");

    property p_sdo_both_edges;
        @(posedge ref_clk_in) disable iff (link_rst)
        locked_out && (pins.rise || pins.fall) && !sync_done
        |=> st_r.out_cnt == (($past(st_r.out_cnt) == 5'h0F) ? 5'h00
                             : $past(st_r.out_cnt) + 5'h01);
    endproperty
    a_sdo_both_edges: assert property (p_sdo_both_edges) // [RULE5]
        else $error("outbound bit not taken on a bit clock edge");

endmodule : display_audio_link_codec_port

// ==== logic/audio_link_pkg.sv ====
// constants and types of the codec-side audio link port
// Overview of operation
// [RULE1] controller sources the 24.00 MHz link bit clock to every codec; the bench controller model drives it with an 80 ns period (12.5 MHz)
// [RULE2] link reset low returns all link logic to its power-on state
// [RULE3] frame sync marks frame boundaries and carries outbound stream tags
// [RULE4] device drives inbound data one bit per bit clock, sampled on rise
// [RULE5] outbound data is sampled on both bit clock edges
// [RULE6] frames are parsed only after a valid frame sync pulse is seen
package audio_link_pkg;

    // ****************************************
    // link figures
    // ****************************************
    localparam int BIT_CLOCK_KHZ = 24000;
    localparam int WORD_BITS     = 16;
    localparam int TAG_BITS      = 4;
    localparam int SYNC_BITS     = 8;
    localparam int SYNC_CNT_W    = 4;
    localparam int WORD_CNT_W    = 5;

    // sync patterns, first bit oldest
    localparam logic [SYNC_BITS-1:0] FRAME_MARK = 8'hF0;
    localparam logic [TAG_BITS-1:0]  TAG_LEAD   = 4'hF;

    localparam logic [SYNC_CNT_W-1:0] SYNC_LAST = 4'h8;
    localparam logic [WORD_CNT_W-1:0] WORD_LAST = 5'h10;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [0:0] {
        WAIT_SYNC,
        LOCKED
    } link_state_t;

    // synchronised link pins and bit clock edges
    typedef struct packed {
        logic reset_n;
        logic sync;
        logic sdo;
        logic rise;
        logic fall;
    } link_pins_t;

    typedef struct packed {
        link_state_t             state;
        logic                    sync_prev;
        logic [SYNC_CNT_W-1:0]   sync_cnt;
        logic [SYNC_BITS-1:0]    sync_hist;
        logic                    frame_start;
        logic [TAG_BITS-1:0]     tag;
        logic                    tag_valid;
        logic [WORD_BITS-1:0]    out_sh;
        logic [WORD_CNT_W-1:0]   out_cnt;
        logic [WORD_BITS-1:0]    out_word;
        logic                    out_valid;
        logic [WORD_BITS-1:0]    in_sh;
        logic [WORD_CNT_W-1:0]   in_left;
        logic                    in_taken;
        logic                    sdi;
        logic                    sdi_oe;
    } port_state_t;

endpackage : audio_link_pkg

// ==== logic/link_sampler.sv ====
// two-stage synchronisers for the link pins and bit clock edge finder
module link_sampler
(
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     bit_clock_in,
    input  wire logic                     reset_n_in,
    input  wire logic                     sync_in,
    input  wire logic                     sdo_in,
    output audio_link_pkg::link_pins_t    pins_out
);

    // ****************************************
    // synchronisers
    // ****************************************
    logic [3:0] stage1_r;
    logic [3:0] stage2_r;
    logic       clk_prev_r;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            stage1_r   <= 4'h0;
            stage2_r   <= 4'h0;
            clk_prev_r <= 1'h0;
        end
        else
        begin
            stage1_r   <= {bit_clock_in, reset_n_in, sync_in, sdo_in};
            stage2_r   <= stage1_r;
            clk_prev_r <= stage2_r[3];
        end
    end

    always_comb
    begin
        pins_out.reset_n = stage2_r[2];
        pins_out.sync    = stage2_r[1];
        pins_out.sdo     = stage2_r[0];
        pins_out.rise    = stage2_r[3] & ~clk_prev_r;
        pins_out.fall    = ~stage2_r[3] & clk_prev_r;
    end

endmodule : link_sampler

// ==== test/link_ctrl_model.sv ====
// behavioural link controller: bit clock, link reset, sync, outbound data
module link_ctrl_model
(
    output logic       bit_clock_out,
    output logic       reset_n_out,
    output logic       sync_out,
    output logic       sdo_out,
    input  wire logic  sdi_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] got_word;

    initial
    begin
        bit_clock_out = 1'b0;
        reset_n_out   = 1'b0;
        sync_out      = 1'b0;
        sdo_out       = 1'b0;
        got_word      = 16'h0000;
    end

    // ****************************************
    // link cycles
    // ****************************************
    task automatic set_reset(input logic v);
        reset_n_out = v;
    endtask : set_reset

    // one 80 ns bit clock period; data changes 24 ns after each edge
    task automatic period(input logic s, input logic d0, input logic d1,
                          input int k);
        sync_out = s;
        sdo_out  = d0;
        #16;
        if (k >= 2 && k <= 17)
            got_word[17-k] = sdi_in;
        bit_clock_out = 1'b1;
        #24 sdo_out = d1;
        #16 bit_clock_out = 1'b0;
        #24;
    endtask : period

    // sync pattern over 8 periods, then n data periods with sync low
    task automatic frame(input logic [7:0] pat, input logic [33:0] bits,
                         input int n);
        for (int i = 0; i < 8; i++)
            period(pat[7-i], 1'b0, 1'b0, 0);
        for (int j = 0; j < n; j++)
            period(1'b0, bits[33-2*j], bits[32-2*j], j + 1);
    endtask : frame
endmodule : link_ctrl_model

// ==== test/tb.sv ====
// self-checking bench for the codec-side audio link port
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk_in, rst_in, bclk, rst_n, sync, sdo;
    logic        sdi, sdi_oe, sdi_wire, taken, locked, fstart, tag_v, word_v;
    logic [3:0]  tag;
    logic [15:0] word, in_word;
    int          n_start, n_tag, n_word, err_count, check_count;

    // controller keeps a weak pull-down on the inbound line
    assign sdi_wire = sdi_oe ? sdi : 1'b0;

    link_ctrl_model model_u (.bit_clock_out(bclk), .reset_n_out(rst_n),
        .sync_out(sync), .sdo_out(sdo), .sdi_in(sdi_wire));

    display_audio_link_codec_port dut_u (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .link_bit_clock_in(bclk), .link_reset_n_in(rst_n),
        .link_frame_sync_in(sync), .link_outbound_serial_in(sdo),
        .link_inbound_serial_in(sdi_wire), .link_inbound_serial_out(sdi),
        .link_inbound_serial_oe_out(sdi_oe), .inbound_word_in(in_word),
        .inbound_taken_out(taken), .locked_out(locked),
        .frame_start_out(fstart), .stream_tag_out(tag),
        .stream_tag_valid_out(tag_v), .outbound_word_out(word),
        .outbound_word_valid_out(word_v));

    // ****************************************
    // pulse counting and checking
    // ****************************************
    always @(posedge ref_clk_in)
    begin
        if (fstart === 1'b1 && taken === 1'b1) n_start <= n_start + 1;
        if (tag_v === 1'b1) n_tag <= n_tag + 1;
        if (word_v === 1'b1) n_word <= n_word + 1;
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_idle();
        chk("locked", 16'h0, {15'h0, locked});
        chk("oe", 16'h0, {15'h0, sdi_oe});
        chk("word", 16'h0, word);
        chk("tag", 16'h0, {12'h0, tag});
    endtask : t_idle

    task automatic t_prelock();
        model_u.frame({4'hF, 4'h5}, 34'h3_FFFF_FFFF, 17);
        repeat (13) @(negedge ref_clk_in);
        chk("tag pulses", 16'h0, n_tag[15:0]);
        chk("word pulses", 16'h0, n_word[15:0]);
        chk("locked", 16'h0, {15'h0, locked});
    endtask : t_prelock

    task automatic t_lock();
        @(negedge ref_clk_in) in_word = 16'hA5C3;
        model_u.frame(8'hF0, {16'h3C96, 16'h6969, 2'b00}, 17);
        repeat (13) @(negedge ref_clk_in);
        chk("starts", 16'h1, n_start[15:0]);
        chk("locked", 16'h1, {15'h0, locked});
        chk("oe", 16'h1, {15'h0, sdi_oe});
        chk("inbound", 16'hA5C3, model_u.got_word);
        chk("out words", 16'h2, n_word[15:0]);
        chk("out word", 16'h6969, word);
    endtask : t_lock

    task automatic t_tags();
        for (int t = 1; t < 16; t++)
        begin
            model_u.frame({4'hF, 4'(t)}, 34'h0, 1);
            repeat (13) @(negedge ref_clk_in);
            chk("tag count", 16'(t), n_tag[15:0]);
            chk("tag", 16'(t), {12'h0, tag});
        end
    endtask : t_tags

    // pattern without the 1111 lead, then a frame mark while locked
    task automatic t_refuse();
        model_u.frame({4'h7, 4'h3}, 34'h0, 1);
        repeat (13) @(negedge ref_clk_in);
        chk("tag count", 16'hF, n_tag[15:0]);
        chk("tag", 16'hF, {12'h0, tag});
        model_u.frame(8'hF0, {16'h1234, 18'h0}, 8);
        repeat (13) @(negedge ref_clk_in);
        chk("starts", 16'h2, n_start[15:0]);
        chk("out word", 16'h1234, word);
    endtask : t_refuse

    task automatic t_link_reset();
        model_u.set_reset(1'b0);
        repeat (25) @(negedge ref_clk_in);
        t_idle();
        model_u.set_reset(1'b1);
        repeat (25) @(negedge ref_clk_in);
        model_u.frame({4'hF, 4'h3}, 34'h0, 1);
        repeat (13) @(negedge ref_clk_in);
        chk("tag count", 16'hF, n_tag[15:0]);
        chk("locked", 16'h0, {15'h0, locked});
    endtask : t_link_reset

    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        rst_in = 1'b1;
        in_word = 16'h0000;
        {n_start, n_tag, n_word, err_count, check_count} = '0;
        repeat (10) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (13) @(negedge ref_clk_in);
        t_idle();
        model_u.set_reset(1'b1);
        repeat (25) @(negedge ref_clk_in);
        t_prelock();
        t_lock();
        t_tags();
        t_refuse();
        t_link_reset();
        end_of_test();
    end
endmodule : tb
